// [include/charger_consts.vh]
// constants for the charger status and watchdog register block
`ifndef CHARGER_CONSTS_VH
`define CHARGER_CONSTS_VH
`define CLK_HZ            20000000
`define WD_TIMEOUT_S      50
`define SLAVE_ADDR        7'h6a
`define OFS_STATUS        8'h00
`define OFS_LIMIT         8'h01
`define UNMAPPED_READ     8'hff
`define BIT_WD_FLAG       7
`define BIT_WATCHDOG_ENABLE_BIT         6
`define BIT_REG_RESET     7
`define LIMIT_RESET       7'h0c
`define FAULT_NONE        4'h0
`define FAULT_IN_LDO_LOW  4'ha
`define FQ_DEPTH_LOG2     3
`endif

// [rtl/charger_status_watchdog_register.v]
// status/watchdog register bank of a battery charger behind a serial two-wire slave
// Functional notes
// - watchdog expiry while enabled sets timeout flag
// - enable bit write one restarts, zero disables
// - two-bit charge state field, read only
// - four-bit fault code field, read only
// - faults queued; each status read shows next
// - queue empty, no active fault: reads zero
// - regulator low with input lockout gives 1010
// - status register resets with enable cleared
// - second register low nibble resets to 1100
// - watchdog times out fifty seconds after restart
// - any host write restarts the watchdog
// - expiry enters default mode, reloads limit default; enable bit kept
`timescale 1ns/1ps
`include "charger_consts.vh"
module charger_status_watchdog_register #(
    parameter [31:0] WD_CYCLES = `WD_TIMEOUT_S * `CLK_HZ
) (
    input  wire       clock_i,
    input  wire       sys_rst_i,
    input  wire       scl_i,
    input  wire       sda_i,
    output wire       sda_o,
    output wire       sda_oe_o,
    input  wire [1:0] charge_state_i,
    input  wire       fault_valid_i,
    input  wire [3:0] fault_code_i,
    input  wire       fault_active_i,
    input  wire       ldo_low_i,
    input  wire       input_uvlo_i,
    output wire       watchdog_timeout_flag_o,
    output wire       watchdog_enable_bit_o,
    output wire       default_mode_o,
    output wire [6:0] limit_control_o
);
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_ADDR = 7'h02;
    localparam [6:0] S_AACK = 7'h04;
    localparam [6:0] S_WR   = 7'h08;
    localparam [6:0] S_WACK = 7'h10;
    localparam [6:0] S_RD   = 7'h20;
    localparam [6:0] S_RACK = 7'h40;
    localparam       FQN    = 1 << `FQ_DEPTH_LOG2;
    // pin synchronisers: stage 1 feeds stage 2 only
    reg        scl_s1_q, scl_s2_q, scl_s3_q;
    reg        sda_s1_q, sda_s2_q, sda_s3_q;
    reg [6:0]  state_q;
    reg [3:0]  bit_cnt_q;
    reg [7:0]  shift_q;
    reg [7:0]  tx_q;
    reg [7:0]  ptr_q;
    reg        ptr_set_q;
    reg        rw_q;
    reg        sda_oe_q;
    reg        sda_low_q;
    reg        wr_stb_q;
    reg [7:0]  wr_addr_q;
    reg [7:0]  wr_data_q;
    reg        pop_q;
    reg        wd_flag_q;
    reg        watchdog_enable_bit_q;
    reg        wd_run_q;
    reg [31:0] wd_cnt_q;
    reg        default_q;
    reg [6:0]  limit_q;
    reg [3:0]  fq_mem_q [0:FQN-1];
    reg [`FQ_DEPTH_LOG2:0] fq_wr_q, fq_rd_q;
    reg [3:0]  last_code_q;
    reg        r7_cond_q;
    reg        r7_pend_q;
    reg        uvlo_q;
    wire start_w = scl_s2_q & sda_s3_q & ~sda_s2_q;
    wire stop_w  = scl_s2_q & ~sda_s3_q & sda_s2_q;
    wire rise_w  = scl_s2_q & ~scl_s3_q;
    wire fall_w  = ~scl_s2_q & scl_s3_q;
    wire fq_empty = (fq_wr_q == fq_rd_q);
    wire fq_full  = (fq_wr_q[`FQ_DEPTH_LOG2] != fq_rd_q[`FQ_DEPTH_LOG2]) &&
                    (fq_wr_q[`FQ_DEPTH_LOG2-1:0] == fq_rd_q[`FQ_DEPTH_LOG2-1:0]);
    wire [3:0] fq_head = fq_mem_q[fq_rd_q[`FQ_DEPTH_LOG2-1:0]];
    wire [3:0] fault_field = !fq_empty ? fq_head :
                             (fault_active_i ? last_code_q : `FAULT_NONE);
    // regulator low with input in lockout or just leaving it
    wire r7_cond = ldo_low_i & (input_uvlo_i | uvlo_q);
    wire r7_evt  = r7_cond & ~r7_cond_q;
    wire push_ext = fault_valid_i & ~fq_full;
    wire push_r7  = (r7_evt | r7_pend_q) & ~fault_valid_i & ~fq_full;
    function [7:0] read_mux;
        input [7:0] addr;
        begin
            case (addr)
                `OFS_STATUS: read_mux = {wd_flag_q, watchdog_enable_bit_q, charge_state_i, fault_field};
                `OFS_LIMIT:  read_mux = {1'b0, limit_q};
                default:     read_mux = `UNMAPPED_READ;
            endcase
        end
    endfunction
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else begin
            scl_s1_q <= scl_i;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end
    // serial slave engine: sample on scl rise, drive on scl fall
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_q   <= S_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            tx_q      <= 8'h00;
            ptr_q     <= 8'h00;
            ptr_set_q <= 1'b0;
            rw_q      <= 1'b0;
            sda_oe_q  <= 1'b0;
            sda_low_q <= 1'b0;
            wr_stb_q  <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
            pop_q     <= 1'b0;
        end else begin
            sda_low_q <= 1'b0;
            wr_stb_q  <= 1'b0;
            pop_q     <= 1'b0;
            if (start_w) begin
                state_q   <= S_ADDR;
                bit_cnt_q <= 4'h0;
                ptr_set_q <= 1'b0;
                sda_oe_q  <= 1'b0;
            end else if (stop_w) begin
                state_q  <= S_IDLE;
                sda_oe_q <= 1'b0;
            end else if (rise_w) begin
                case (state_q)
                    S_ADDR, S_WR: begin
                        shift_q   <= {shift_q[6:0], sda_s2_q};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    S_RD: bit_cnt_q <= bit_cnt_q + 4'h1;
                    S_RACK: begin
                        // a byte read completes here, acked or not
                        pop_q <= (ptr_q == `OFS_STATUS);
                        ptr_q <= ptr_q + 8'h01;
                        if (sda_s2_q) begin
                            state_q <= S_IDLE;
                        end
                    end
                    default: ;
                endcase
            end else if (fall_w) begin
                case (state_q)
                    S_ADDR: begin
                        if (bit_cnt_q == 4'h8) begin
                            if (shift_q[7:1] == `SLAVE_ADDR) begin
                                sda_oe_q <= 1'b1;
                                rw_q     <= shift_q[0];
                                state_q  <= S_AACK;
                            end else begin
                                state_q <= S_IDLE;
                            end
                        end
                    end
                    S_AACK: begin
                        bit_cnt_q <= 4'h0;
                        if (rw_q) begin
                            tx_q     <= read_mux(ptr_q);
                            sda_oe_q <= ~|(read_mux(ptr_q) & 8'h80); // pull low for a zero msb
                            state_q  <= S_RD;
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q  <= S_WR;
                        end
                    end
                    S_WR: begin
                        if (bit_cnt_q == 4'h8) begin
                            sda_oe_q <= 1'b1;
                            state_q  <= S_WACK;
                            if (!ptr_set_q) begin
                                ptr_q     <= shift_q;
                                ptr_set_q <= 1'b1;
                            end else begin
                                wr_stb_q  <= 1'b1;
                                wr_addr_q <= ptr_q;
                                wr_data_q <= shift_q;
                                ptr_q     <= ptr_q + 8'h01;
                            end
                        end
                    end
                    S_WACK: begin
                        sda_oe_q  <= 1'b0;
                        bit_cnt_q <= 4'h0;
                        state_q   <= S_WR;
                    end
                    S_RD: begin
                        if (bit_cnt_q == 4'h8) begin
                            sda_oe_q <= 1'b0;
                            state_q  <= S_RACK;
                        end else begin
                            tx_q     <= {tx_q[6:0], 1'b0};
                            sda_oe_q <= ~tx_q[6];
                        end
                    end
                    S_RACK: begin
                        tx_q      <= read_mux(ptr_q);
                        sda_oe_q  <= ~|(read_mux(ptr_q) & 8'h80);
                        bit_cnt_q <= 4'h0;
                        state_q   <= S_RD;
                    end
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end
    // watchdog and host registers
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            watchdog_enable_bit_q   <= 1'b0;
            wd_flag_q <= 1'b0;
            wd_run_q  <= 1'b0;
            wd_cnt_q  <= 32'h0000_0000;
            default_q <= 1'b1;
            limit_q   <= `LIMIT_RESET;
        end else begin
            if (wr_stb_q) begin
                wd_run_q  <= 1'b1;
                wd_cnt_q  <= 32'h0000_0000;
                default_q <= 1'b0;
                wd_flag_q <= 1'b0; // held until a host write re-arms the timer
                if (wr_addr_q == `OFS_STATUS) begin
                    watchdog_enable_bit_q <= wr_data_q[`BIT_WATCHDOG_ENABLE_BIT];
                end else if (wr_addr_q == `OFS_LIMIT) begin
                    if (wr_data_q[`BIT_REG_RESET]) begin
                        limit_q <= `LIMIT_RESET;
                        watchdog_enable_bit_q <= 1'b0;
                    end else begin
                        limit_q <= wr_data_q[6:0];
                    end
                end
            end else if (watchdog_enable_bit_q && wd_run_q) begin
                if (wd_cnt_q == WD_CYCLES - 32'd1) begin
                    wd_flag_q <= 1'b1;
                    wd_run_q  <= 1'b0;
                    default_q <= 1'b1;
                    limit_q   <= `LIMIT_RESET;
                end else begin
                    wd_cnt_q <= wd_cnt_q + 32'd1;
                end
            end
        end
    end
    // fault queue; a full queue drops new codes
    integer i;
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            for (i = 0; i < FQN; i = i + 1) begin
                fq_mem_q[i] <= `FAULT_NONE;
            end
            fq_wr_q     <= {(`FQ_DEPTH_LOG2+1){1'b0}};
            fq_rd_q     <= {(`FQ_DEPTH_LOG2+1){1'b0}};
            last_code_q <= `FAULT_NONE;
            r7_cond_q   <= 1'b0;
            r7_pend_q   <= 1'b0;
            uvlo_q      <= 1'b0;
        end else begin
            uvlo_q    <= input_uvlo_i;
            r7_cond_q <= r7_cond;
            r7_pend_q <= (r7_evt | r7_pend_q) & ~push_r7 & ~fq_full;
            if (push_ext || push_r7) begin
                fq_mem_q[fq_wr_q[`FQ_DEPTH_LOG2-1:0]] <= push_ext ? fault_code_i : `FAULT_IN_LDO_LOW;
                fq_wr_q <= fq_wr_q + 1'b1;
            end
            if (pop_q && !fq_empty) begin
                last_code_q <= fq_head;
                fq_rd_q     <= fq_rd_q + 1'b1;
            end
        end
    end
    assign sda_o                   = sda_low_q;
    assign sda_oe_o                = sda_oe_q;
    assign watchdog_timeout_flag_o = wd_flag_q;
    assign watchdog_enable_bit_o   = watchdog_enable_bit_q;
    assign default_mode_o          = default_q;
    assign limit_control_o         = limit_q;
endmodule

// [test/i2c_host_model.sv]
// two-wire host master model that talks to the charger register block
`timescale 1ns/1ps
`include "charger_consts.vh"
module i2c_host_model (
    input  wire clock_i,
    input  wire sda_i,
    output reg  scl_o,
    output reg  sda_o
);
    integer nak;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        nak = 0;
    end
    // half period of eight clocks keeps scl above the five-clock minimum
    task hw;
        repeat (8) @(posedge clock_i);
    endtask
    // data moves one clock after scl falls, so no false start or stop is seen
    task bit_io(input b, output r);
        @(posedge clock_i);
        sda_o <= b;
        hw;
        scl_o <= 1'b1;
        hw;
        r = sda_i;
        scl_o <= 1'b0;
    endtask
    task start;
        @(posedge clock_i);
        sda_o <= 1'b1;
        hw;
        scl_o <= 1'b1;
        hw;
        sda_o <= 1'b0;
        hw;
        scl_o <= 1'b0;
    endtask
    task stop;
        @(posedge clock_i);
        sda_o <= 1'b0;
        hw;
        scl_o <= 1'b1;
        hw;
        sda_o <= 1'b1;
        hw;
    endtask
    task byte_io(input [7:0] d, input ab, output [7:0] q, output a);
        integer i;
        for (i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ab, a);
    endtask
    task wb(input [7:0] d);
        reg [7:0] q;
        reg       a;
        byte_io(d, 1'b1, q, a);
        if (a) nak++;
    endtask
    // any write restarts the device watchdog, so the host keeps writing
    task wr(input [7:0] p, input [7:0] v);
        start;
        wb({`SLAVE_ADDR, 1'b0});
        wb(p);
        wb(v);
        stop;
    endtask
    task rd(input [7:0] p, output [7:0] v);
        reg a;
        start;
        wb({`SLAVE_ADDR, 1'b0});
        wb(p);
        start;
        wb({`SLAVE_ADDR, 1'b1});
        byte_io(8'hff, 1'b1, v, a);
        stop;
    endtask
endmodule

// [test/charger_status_watchdog_register_sva.sv]
// assertion checker for the charger status and watchdog register block
`timescale 1ns/1ps
`include "charger_consts.vh"
module charger_status_watchdog_register_sva (
    input wire       clock_i,
    input wire       sys_rst_i,
    input wire       scl_i,
    input wire       sda_i,
    input wire       sda_o,
    input wire       sda_oe_o,
    input wire [1:0] charge_state_i,
    input wire       fault_valid_i,
    input wire [3:0] fault_code_i,
    input wire       fault_active_i,
    input wire       ldo_low_i,
    input wire       input_uvlo_i,
    input wire       watchdog_timeout_flag_o,
    input wire       watchdog_enable_bit_o,
    input wire       default_mode_o,
    input wire [6:0] limit_control_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    a_reset_enable_off: assert property ($fell(sys_rst_i) |-> !watchdog_enable_bit_o)
        else $error("enable bit set after reset");
    a_reset_limit_value: assert property ($fell(sys_rst_i) |-> limit_control_o == `LIMIT_RESET)
        else $error("limit field wrong after reset");
    a_reset_bus_idle: assert property ($fell(sys_rst_i) |-> !watchdog_timeout_flag_o && default_mode_o && !sda_oe_o)
        else $error("flag, mode or data pin wrong after reset");
    a_flag_needs_enable: assert property ($rose(watchdog_timeout_flag_o) |-> $past(watchdog_enable_bit_o))
        else $error("timeout flag rose with watchdog disabled");
    a_expiry_defaults: assert property ($rose(watchdog_timeout_flag_o) |->
        ##[0:1] (default_mode_o && limit_control_o == `LIMIT_RESET))
        else $error("expiry did not reload defaults");
    a_flag_in_default: assert property (watchdog_timeout_flag_o |-> default_mode_o)
        else $error("timeout flag outside default mode");
    a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data pin changed while clock high");
    a_sda_low_only: assert property (!sda_o)
        else $error("data pin driven high");
    a_flag_host_clear: assert property ($fell(watchdog_timeout_flag_o) |-> $fell(default_mode_o))
        else $error("timeout flag cleared without leaving default mode");
    a_default_reload: assert property ($rose(default_mode_o) |-> limit_control_o == `LIMIT_RESET)
        else $error("default mode entered without limit reload");
    c_expiry: cover property ($rose(watchdog_timeout_flag_o));
    c_ack: cover property ($rose(sda_oe_o));
    c_host_mode: cover property ($fell(default_mode_o));
endmodule
bind charger_status_watchdog_register charger_status_watchdog_register_sva u_sva (.clock_i, .sys_rst_i, .scl_i,
    .sda_i, .sda_o, .sda_oe_o, .charge_state_i, .fault_valid_i, .fault_code_i, .fault_active_i, .ldo_low_i,
    .input_uvlo_i, .watchdog_timeout_flag_o, .watchdog_enable_bit_o, .default_mode_o, .limit_control_o);

// [test/tb.sv]
// self-checking testbench for the charger status and watchdog register block
`timescale 1ns/1ps
`include "charger_consts.vh"
module tb;
    reg        clk = 1'b0;
    reg        rst = 1'b1;
    reg  [1:0] cs = 2'h0;
    reg        fv = 1'b0;
    reg  [3:0] fc = 4'h0;
    reg        fa = 1'b0;
    reg        ldo = 1'b0;
    reg        uvlo = 1'b0;
    wire       scl, sdam, sdo, oe, flag, wen, dmode;
    wire [6:0] lim;
    wire       sda = sdam & !(oe && !sdo);
    integer    err_total = 0;
    integer    check_count = 0;
    reg  [7:0] v;
    integer    k;
    always #25 clk = ~clk;
    i2c_host_model m (.clock_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sdam));
    charger_status_watchdog_register #(.WD_CYCLES(3000)) u_dut (.clock_i(clk), .sys_rst_i(rst), .scl_i(scl),
        .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe), .charge_state_i(cs), .fault_valid_i(fv), .fault_code_i(fc),
        .fault_active_i(fa), .ldo_low_i(ldo), .input_uvlo_i(uvlo), .watchdog_timeout_flag_o(flag),
        .watchdog_enable_bit_o(wen), .default_mode_o(dmode), .limit_control_o(lim));
    task chk(input [8*10-1:0] nm, input [7:0] e, input [7:0] g);
        check_count++;
        if (g !== e) begin
            $display("unexpected %0s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task push(input [3:0] c);
        @(posedge clk);
        fv <= 1'b1;
        fc <= c;
        @(posedge clk);
        fv <= 1'b0;
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task t_reset;
        chk("enable", 8'h00, wen);
        chk("limit", 8'h0c, lim);
        m.rd(`OFS_LIMIT, v);
        chk("reg1", 8'h0c, v);
        m.rd(`OFS_STATUS, v);
        chk("wd bits", 8'h00, v[7:6]);
        m.rd(8'h05, v);
        chk("unmapped", `UNMAPPED_READ, v);
        $display("reset test done");
    endtask
    task t_watchdog;
        m.wr(`OFS_STATUS, 8'h40);
        chk("enable", 8'h01, wen);
        chk("default", 8'h00, dmode);
        repeat (2100) @(posedge clk);
        m.wr(`OFS_LIMIT, 8'h35);
        chk("limit", 8'h35, lim);
        repeat (2100) @(posedge clk);
        chk("flag", 8'h00, flag);
        k = 0;
        while (flag !== 1'b1 && k < 1200) begin
            @(posedge clk);
            k++;
        end
        // restart lands inside the write, a little before its stop
        chk("wd span", 8'h01, k >= 840 && k <= 905);
        chk("default", 8'h01, dmode);
        chk("limit", 8'h0c, lim);
        m.rd(`OFS_STATUS, v);
        chk("status b7", 8'h01, v[7]);
        m.wr(`OFS_STATUS, 8'h00);
        repeat (3500) @(posedge clk);
        chk("flag off", 8'h00, {wen, flag});
        $display("watchdog test done");
    endtask
    task t_state;
        for (k = 0; k < 4; k++) begin
            cs <= k[1:0];
            m.rd(`OFS_STATUS, v);
            chk("state", k[7:0], v[5:4]);
        end
        $display("state test done");
    endtask
    task t_fault;
        for (k = 1; k <= 8; k++) push(k[3:0]);
        for (k = 1; k <= 10; k++) begin
            if (k == 9) begin
                push(4'h9);
                push(4'ha);
                m.wr(`OFS_LIMIT, 8'h0c);
            end
            m.rd(`OFS_STATUS, v);
            chk("fault", k[7:0], v[3:0]);
        end
        m.rd(`OFS_STATUS, v);
        chk("fault end", 8'h00, v[3:0]);
        uvlo <= 1'b1;
        repeat (3) @(posedge clk);
        ldo <= 1'b1;
        m.rd(`OFS_STATUS, v);
        chk("ldo fault", `FAULT_IN_LDO_LOW, v[3:0]);
        ldo <= 1'b0;
        uvlo <= 1'b0;
        m.rd(`OFS_STATUS, v);
        chk("fault end", 8'h00, v[3:0]);
        uvlo <= 1'b1;
        @(posedge clk);
        uvlo <= 1'b0;
        ldo <= 1'b1;
        m.rd(`OFS_STATUS, v);
        chk("ldo exit", `FAULT_IN_LDO_LOW, v[3:0]);
        ldo <= 1'b0;
        fa <= 1'b1;
        m.rd(`OFS_STATUS, v);
        chk("fault hold", `FAULT_IN_LDO_LOW, v[3:0]);
        fa <= 1'b0;
        chk("nacks", 8'h00, m.nak[7:0]);
        $display("fault test done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_reset;
        t_watchdog;
        t_state;
        t_fault;
        complete_run;
    end
    // whole sequence needs roughly twenty-six thousand clocks
    initial begin
        #4500000;
        err_total++;
        complete_run;
    end
endmodule
